// >>> design/sync_serial_port_defs.vh
// Constants for the synchronous serial port block.
// Assumes inclusion by its bare name from the design file.
`ifndef SYNC_SERIAL_PORT_DEFS_VH
`define SYNC_SERIAL_PORT_DEFS_VH
`define SSP_MODE_W 4
`define SSP_MODE_SLAVE_SS 4'h4
`define SSP_MODE_SLAVE_NOSS 4'h5
`define SSP_MODE_MASTER_TW 4'h8
`define SSP_BYTE_BITS 4'h8
`define SSP_ACK_CLOCK 4'h9
`define SSP_BRG_RESET 8'h00
`define SSP_BRG_DEFAULT 8'h04
`endif

// >>> design/sync_serial_port.v
// Synchronous serial port: two-wire master transmit and SPI slave.
// Assumes a single 100 MHz clock; link pins are asynchronous and
// synchronised here; open-drain pins resolved outside.
`timescale 1ns/1ps
`include "sync_serial_port_defs.vh"

// Behaviour
// R01 - Buffer write sets buffer-full and starts the baud generator.
// R02 - Data bit changes after SCL falls; SCL low one rollover.
// R03 - Released SCL stays high one rollover before going low.
// R04 - Eighth falling edge clears buffer-full and releases SDA.
// R05 - Ninth falling edge samples SDA into ack status bit.
// R06 - After ninth clock set interrupt flag, stop generator, hold SCL low.
// R07 - Address byte: seven bits then direction bit, MSB first.
// R08 - Write while shifting sets collision flag, buffer unchanged. Here only two-wire master shifting flags it; SPI slave writes are queued.
// R09 - Collision flag cleared only by software.
// R10 - Slave drives acknowledge low on match or good data.
// R11 - SPI slave shifts on external SCK; flag after last bit.
// R12 - SPI slave works in sleep; received byte raises wake.
// R13 - SCK already idle at polarity level before enabling slave.
// R14 - Slave-select gating only when mode field equals 04h.
// R15 - Select low in gated mode enables transfer and drives SDO.
// R16 - Select high stops driving SDO immediately.
// R17 - Select high or port disable forces bit counter to zero.
// R18 - Software sets select control when edge select bit set.
// R19 - SDO as input suppresses transmission; SDI still receives.
module sync_serial_port #(
  parameter [7:0] BRG_RELOAD = `SSP_BRG_DEFAULT
) (
  input wire mclk_i,
  input wire rst_n_i,
  input wire port_enable_bit_i,
  input wire [3:0] mode_i,
  input wire clock_polarity_bit_i,
  input wire clock_edge_i,
  input wire sdo_input_i,
  input wire sleep_i,
  input wire [7:0] wr_data_i,
  input wire wr_valid_i,
  output wire wr_ready_o,
  input wire write_collision_flag_clear_i,
  input wire int_clear_i,
  output wire [7:0] rd_data_o,
  output wire rd_valid_o,
  input wire rd_ready_i,
  output reg buffer_full_flag_o,
  output reg write_collision_flag_o,
  output reg ack_status_bit_o,
  output reg port_interrupt_flag_o,
  output reg wake_o,
  input wire scl_i,
  output wire scl_oe_n_o,
  input wire sda_i,
  output wire sda_oe_n_o,
  input wire sck_i,
  input wire ss_n_i,
  input wire sdi_i,
  output reg sdo_o,
  output wire sdo_oe_n_o
);

  // ****************************************************
  // Pin synchronisers
  // ****************************************************
  reg [1:0] scl_s_r, sda_s_r, sck_s_r, ss_s_r, sdi_s_r;
  reg sck_d_r;
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      sck_s_r <= 2'h0;
      ss_s_r <= 2'h3;
      sdi_s_r <= 2'h0;
      sck_d_r <= 1'b0;
    end else begin
      scl_s_r <= {scl_s_r[0], scl_i};
      sda_s_r <= {sda_s_r[0], sda_i};
      sck_s_r <= {sck_s_r[0], sck_i};
      ss_s_r <= {ss_s_r[0], ss_n_i};
      sdi_s_r <= {sdi_s_r[0], sdi_i};
      sck_d_r <= sck_s_r[1];
    end
  end

  wire sda_in = sda_s_r[1];
  wire sck_in = sck_s_r[1];
  wire ss_in = ss_s_r[1];
  wire sdi_in = sdi_s_r[1];
  wire sck_rise = sck_in & ~sck_d_r;
  wire sck_fall = ~sck_in & sck_d_r;

  // ****************************************************
  // Mode decode
  // ****************************************************
  wire master_mode = port_enable_bit_i & (mode_i == `SSP_MODE_MASTER_TW);
  wire gated_mode = mode_i == `SSP_MODE_SLAVE_SS; // see R14
  wire slave_mode = port_enable_bit_i &
                    (gated_mode | mode_i == `SSP_MODE_SLAVE_NOSS);
  wire slave_sel = slave_mode & ~(gated_mode & ss_in); // see R15
  wire port_reset = ~port_enable_bit_i | (gated_mode & ss_in); // see R17
  // Sample edge: polarity xor clock edge select picks leading/trailing
  wire samp_edge = (clock_polarity_bit_i ^ clock_edge_i) ? sck_fall
                                                         : sck_rise;
  wire shift_edge = (clock_polarity_bit_i ^ clock_edge_i) ? sck_rise
                                                          : sck_fall;

  // ****************************************************
  // Two-entry transmit buffer
  // ****************************************************
  reg [7:0] tbuf_r [0:1];
  reg tb_wp_r, tb_rp_r;
  reg [1:0] tb_cnt_r;
  wire tb_full = tb_cnt_r == 2'h2;
  wire tb_empty = tb_cnt_r == 2'h0;
  wire tb_pop;
  reg [2:0] mstate_r;
  wire shifting;
  // Collision case refuses the word, so ready stays high for it
  assign wr_ready_o = ~tb_full;
  wire wr_take = wr_valid_i & ~tb_full & ~shifting; // see R08
  wire wr_coll = wr_valid_i & shifting; // see R08

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tb_wp_r <= 1'b0;
      tb_rp_r <= 1'b0;
      tb_cnt_r <= 2'h0;
      tbuf_r[0] <= 8'h00;
      tbuf_r[1] <= 8'h00;
    end else begin
      if (wr_take) begin
        tbuf_r[tb_wp_r] <= wr_data_i;
        tb_wp_r <= ~tb_wp_r;
      end
      if (tb_pop)
        tb_rp_r <= ~tb_rp_r;
      tb_cnt_r <= tb_cnt_r + {1'b0, wr_take} - {1'b0, tb_pop};
    end
  end
  wire [7:0] tb_head = tbuf_r[tb_rp_r];

  // ****************************************************
  // Two-wire master transmitter
  // ****************************************************
  localparam [2:0] M_IDLE = 3'h0;
  localparam [2:0] M_LOW = 3'h1;
  localparam [2:0] M_HIGH = 3'h2;
  localparam [2:0] M_HOLD = 3'h3;
  reg [7:0] brg_r;
  reg [7:0] m_shift_r;
  reg [3:0] m_clk_r;
  reg scl_drv_r, sda_drv_r;
  wire brg_roll = brg_r == `SSP_BRG_RESET;
  wire m_start = (mstate_r == M_IDLE || mstate_r == M_HOLD) &
                 master_mode & ~tb_empty;
  wire s_start;
  assign tb_pop = m_start | s_start;
  assign shifting = (mstate_r == M_LOW | mstate_r == M_HIGH) &
                    (m_clk_r != `SSP_ACK_CLOCK);

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mstate_r <= M_IDLE;
      brg_r <= `SSP_BRG_RESET;
      m_shift_r <= 8'h00;
      m_clk_r <= 4'h0;
      scl_drv_r <= 1'b0;
      sda_drv_r <= 1'b0;
      ack_status_bit_o <= 1'b0;
    end else if (!master_mode) begin
      mstate_r <= M_IDLE;
      scl_drv_r <= 1'b0;
      sda_drv_r <= 1'b0;
      m_clk_r <= 4'h0;
    end else begin
      if (!brg_roll)
        brg_r <= brg_r - 8'h01;
      case (mstate_r)
        M_IDLE, M_HOLD: begin
          if (m_start) begin // see R01
            m_shift_r <= {tb_head[6:0], 1'b0}; // see R07
            sda_drv_r <= ~tb_head[7]; // see R02
            scl_drv_r <= 1'b1;
            m_clk_r <= 4'h1;
            brg_r <= BRG_RELOAD;
            mstate_r <= M_LOW;
          end
        end
        M_LOW: begin
          if (brg_roll) begin // see R02
            scl_drv_r <= 1'b0;
            brg_r <= BRG_RELOAD;
            mstate_r <= M_HIGH;
          end
        end
        M_HIGH: begin
          if (brg_roll) begin // see R03
            scl_drv_r <= 1'b1;
            brg_r <= BRG_RELOAD;
            if (m_clk_r == `SSP_ACK_CLOCK) begin
              ack_status_bit_o <= sda_in; // see R05
              sda_drv_r <= 1'b0;
              m_clk_r <= 4'h0;
              mstate_r <= M_HOLD; // see R06
            end else begin
              if (m_clk_r == `SSP_BYTE_BITS)
                sda_drv_r <= 1'b0; // see R04
              else
                sda_drv_r <= ~m_shift_r[7]; // see R07
              m_shift_r <= {m_shift_r[6:0], 1'b0};
              m_clk_r <= m_clk_r + 4'h1;
              mstate_r <= M_LOW;
            end
          end
        end
        default: mstate_r <= M_IDLE;
      endcase
    end
  end
  // Open drain: enable low pulls the wire low
  assign scl_oe_n_o = ~scl_drv_r;
  assign sda_oe_n_o = ~sda_drv_r;
  wire m_byte_end = master_mode & mstate_r == M_HIGH & brg_roll &
                    m_clk_r == `SSP_BYTE_BITS;
  wire m_ack_end = master_mode & mstate_r == M_HIGH & brg_roll &
                   m_clk_r == `SSP_ACK_CLOCK;

  // ****************************************************
  // SPI slave
  // ****************************************************
  reg [7:0] s_shift_r;
  reg [2:0] s_cnt_r;
  reg s_loaded_r;
  reg [7:0] rx_r [0:1];
  reg rx_wp_r, rx_rp_r;
  reg [1:0] rx_cnt_r;
  assign s_start = slave_sel & ~s_loaded_r & ~tb_empty & ~samp_edge &
                   s_cnt_r == 3'h0;
  wire s_done = slave_sel & samp_edge & s_cnt_r == 3'h7; // see R11
  wire rx_push = s_done & rx_cnt_r != 2'h2;
  wire rx_pop = rd_valid_o & rd_ready_i;

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_shift_r <= 8'h00;
      s_cnt_r <= 3'h0;
      s_loaded_r <= 1'b0;
      sdo_o <= 1'b0;
    end else if (port_reset | ~slave_mode) begin
      s_cnt_r <= 3'h0; // see R17
      s_loaded_r <= 1'b0;
    end else begin
      if (s_start) begin
        s_shift_r <= tb_head;
        sdo_o <= tb_head[7];
        s_loaded_r <= 1'b1;
      end else if (samp_edge) begin // see R11
        s_shift_r <= {s_shift_r[6:0], sdi_in}; // see R19
        s_cnt_r <= s_cnt_r + 3'h1;
        if (s_cnt_r == 3'h7)
          s_loaded_r <= 1'b0;
      end else if (shift_edge) begin
        sdo_o <= s_shift_r[7];
      end
    end
  end
  // Drive SDO only when selected and SDO not an input
  assign sdo_oe_n_o = ~(slave_sel & ~sdo_input_i); // see R16 see R19

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_wp_r <= 1'b0;
      rx_rp_r <= 1'b0;
      rx_cnt_r <= 2'h0;
      rx_r[0] <= 8'h00;
      rx_r[1] <= 8'h00;
    end else begin
      if (rx_push) begin
        rx_r[rx_wp_r] <= {s_shift_r[6:0], sdi_in};
        rx_wp_r <= ~rx_wp_r;
      end
      if (rx_pop)
        rx_rp_r <= ~rx_rp_r;
      rx_cnt_r <= rx_cnt_r + {1'b0, rx_push} - {1'b0, rx_pop};
    end
  end
  assign rd_valid_o = rx_cnt_r != 2'h0;
  assign rd_data_o = rx_r[rx_rp_r];

  // ****************************************************
  // Status flags
  // ****************************************************
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      buffer_full_flag_o <= 1'b0;
      write_collision_flag_o <= 1'b0;
      port_interrupt_flag_o <= 1'b0;
      wake_o <= 1'b0;
    end else begin
      if (wr_take)
        buffer_full_flag_o <= 1'b1; // see R01
      else if (m_byte_end)
        buffer_full_flag_o <= 1'b0; // see R04
      if (wr_coll)
        write_collision_flag_o <= 1'b1; // see R09
      else if (write_collision_flag_clear_i)
        write_collision_flag_o <= 1'b0;
      if (m_ack_end | s_done)
        port_interrupt_flag_o <= 1'b1; // see R06
      else if (int_clear_i)
        port_interrupt_flag_o <= 1'b0;
      wake_o <= s_done & sleep_i; // see R12
    end
  end

endmodule // sync_serial_port

// >>> tb/sync_serial_port_monitor.sv
// Checker on the serial port top ports.
// Assumes the default reload of 4: five cycles per SCL phase.
`timescale 1ns/1ps
module sync_serial_port_monitor (
  input wire mclk_i,
  input wire rst_n_i,
  input wire port_enable_bit_i,
  input wire [3:0] mode_i,
  input wire ss_n_i,
  input wire sdo_input_i,
  input wire wr_valid_i,
  input wire write_collision_flag_clear_i,
  input wire buffer_full_flag_o,
  input wire write_collision_flag_o,
  input wire port_interrupt_flag_o,
  input wire scl_oe_n_o,
  input wire sda_oe_n_o,
  input wire sdo_oe_n_o
);
  // ******
  // Checks
  // ******
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  wire mst = port_enable_bit_i && mode_i == 4'h8;
  wire sel = port_enable_bit_i && mode_i == 4'h4;
  AST_WR_FULL: assert property (
    $rose(buffer_full_flag_o) |-> $past(wr_valid_i)) else $error("full");
  AST_SCL_LOW: assert property (
    mst && $fell(scl_oe_n_o) |-> (!scl_oe_n_o) [*5]) else $error("low");
  AST_SCL_HIGH: assert property (
    mst && $rose(scl_oe_n_o) |-> scl_oe_n_o [*5]) else $error("high");
  AST_SDA_HOLD: assert property (
    mst && scl_oe_n_o && $past(scl_oe_n_o) |-> $stable(sda_oe_n_o))
    else $error("sda moved");
  AST_INT_HOLD: assert property (
    mst && $rose(port_interrupt_flag_o) |-> ##1 (!scl_oe_n_o) [*4])
    else $error("scl free");
  AST_WRITE_COLLISION_FLAG_HOLD: assert property (
    write_collision_flag_o && !write_collision_flag_clear_i |=> write_collision_flag_o)
    else $error("write_collision_flag lost");
  AST_SDO_SEL: assert property (
    sel && ss_n_i [*5] |-> sdo_oe_n_o) else $error("sdo driven");
  AST_SDO_INPUT: assert property (
    sdo_input_i |-> sdo_oe_n_o) else $error("sdo input driven");
endmodule // sync_serial_port_monitor

bind sync_serial_port sync_serial_port_monitor mon_u (.mclk_i, .rst_n_i,
  .port_enable_bit_i, .mode_i, .ss_n_i, .sdo_input_i, .wr_valid_i,
  .write_collision_flag_clear_i, .buffer_full_flag_o, .write_collision_flag_o,
  .port_interrupt_flag_o, .scl_oe_n_o, .sda_oe_n_o, .sdo_oe_n_o);

// >>> tb/tw_slave_model.sv
// Two-wire slave: collects bits on SCL rise, answers the ninth slot.
// Assumes resolved open-drain lines with pull-ups.
`timescale 1ns/1ps
module tw_slave_model (
  input wire mclk_i,
  input wire rst_n_i,
  input wire scl_i,
  input wire sda_i,
  input wire nack_i,
  output reg sda_pull_o,
  output reg [7:0] byte_o
);
  reg scl_q;
  reg [3:0] cnt;
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_q <= 1'h1;
      cnt <= 4'h0;
      sda_pull_o <= 1'h0;
      byte_o <= 8'h00;
    end else begin
      scl_q <= scl_i;
      if (scl_i && !scl_q) begin
        cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
        if (cnt != 4'h8)
          byte_o <= {byte_o[6:0], sda_i};
      end
      if (!scl_i && scl_q)
        sda_pull_o <= (cnt == 4'h8) && !nack_i;
    end
  end
endmodule // tw_slave_model

// >>> tb/serial_port_i2c_tx_spi_slave_test.sv
// Bench: master send, collision, SPI slave receive.
// Assumes the two-wire slave model and pull-ups on open lines.
`timescale 1ns/1ps
module serial_port_i2c_tx_spi_slave_test;
  reg mclk_i = 0, rst_n_i = 0, en = 0, sdo_in = 0, sleep = 0, woke = 0;
  reg wr_valid = 0, write_collision_flag_clr = 0, int_clr = 0, rd_ready = 0, nack = 0;
  reg sck = 0, ss_n = 1, sdi = 0, clock_polarity_bit = 0, cke = 0;
  reg [3:0] mode = 4'h8;
  reg [7:0] wr_data = 8'h00, d, q[$], got = 8'h00, tx = 8'h00;
  wire wr_ready, rd_valid, bf, write_collision_flag, ack, irq, wake, scl_oe_n, sda_oe_n;
  wire sdo, sdo_oe_n, pull;
  wire [7:0] rd_data, rx;
  wire sda = sda_oe_n & ~pull;
  integer num_errors = 0, checks = 0, i, n;
  sync_serial_port dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .port_enable_bit_i(en), .mode_i(mode), .clock_polarity_bit_i(clock_polarity_bit),
    .clock_edge_i(cke), .sdo_input_i(sdo_in), .sleep_i(sleep),
    .wr_data_i(wr_data), .wr_valid_i(wr_valid), .wr_ready_o(wr_ready),
    .write_collision_flag_clear_i(write_collision_flag_clr), .int_clear_i(int_clr), .rd_data_o(rd_data),
    .rd_valid_o(rd_valid), .rd_ready_i(rd_ready),
    .buffer_full_flag_o(bf), .write_collision_flag_o(write_collision_flag),
    .ack_status_bit_o(ack), .port_interrupt_flag_o(irq), .wake_o(wake),
    .scl_i(scl_oe_n), .scl_oe_n_o(scl_oe_n), .sda_i(sda),
    .sda_oe_n_o(sda_oe_n), .sck_i(sck), .ss_n_i(ss_n), .sdi_i(sdi),
    .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n));
  tw_slave_model slave_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .scl_i(scl_oe_n), .sda_i(sda), .nack_i(nack), .sda_pull_o(pull),
    .byte_o(rx));
  // *****
  // Tasks
  // *****
  initial forever #5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) if (wake) woke <= 1;
  task check(input string name, input logic [7:0] seen, exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("BAD %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task pulse_int;
    begin
      @(posedge mclk_i) int_clr <= 1;
      @(posedge mclk_i) int_clr <= 0;
    end
  endtask
  task send(input [7:0] v);
    begin
      @(posedge mclk_i);
      wr_data <= v;
      wr_valid <= 1;
      @(posedge mclk_i);
      wr_valid <= 0;
    end
  endtask
  task wait_irq;
    begin
      for (i = 0; i < 400 && irq !== 1'h1; i = i + 1) @(posedge mclk_i);
      check("irq", irq, 1);
      check("rx", rx, d);
      check("bf", bf, 0);
      check("scl", scl_oe_n, 0);
    end
  endtask
  task spi(input [7:0] v, input integer cnt);
    begin
      for (i = 7; i > 7 - cnt; i = i - 1) begin
        sdi <= v[i];
        repeat (2) @(posedge mclk_i);
        got = {got[6:0], sdo};
        sck <= ~sck;
        repeat (4) @(posedge mclk_i);
        sck <= ~sck;
        repeat (2) @(posedge mclk_i);
      end
    end
  endtask
  task drain;
    begin
      rd_ready <= 1;
      for (n = 0; n < 30 && q.size() > 0; n = n + 1) begin
        @(posedge mclk_i);
        if (rd_valid === 1'h1) check("rd", rd_data, q.pop_front());
      end
      check("left", q.size(), 0);
      rd_ready <= 0;
    end
  endtask
  initial begin
    #300000;
    num_errors = num_errors + 1;
    report_and_stop;
  end
  initial begin
    d = $urandom(32'h9c75);
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1;
    en <= 1;
    for (n = 0; n < 4; n = n + 1) begin
      d = $urandom;
      nack <= n[0];
      send(d);
      @(posedge mclk_i);
      check("bf", bf, 1);
      wait_irq;
      check("ack", ack, n[0]);
      pulse_int;
    end
    $display("master send done");
    d = $urandom;
    send(d);
    repeat (20) @(posedge mclk_i);
    send(~d);
    repeat (2) @(posedge mclk_i);
    check("write_collision_flag", write_collision_flag, 1);
    check("ready", wr_ready, 1);
    wait_irq;
    repeat (50) @(posedge mclk_i);
    check("write_collision_flag", write_collision_flag, 1);
    @(posedge mclk_i) write_collision_flag_clr <= 1;
    @(posedge mclk_i) write_collision_flag_clr <= 0;
    pulse_int;
    check("write_collision_flag", write_collision_flag, 0);
    $display("collision done");
    en <= 0;
    mode <= 4'h4;
    @(posedge mclk_i) en <= 1;
    sleep <= 1;
    ss_n <= 0;
    spi($urandom, 3);
    ss_n <= 1;
    repeat (8) @(posedge mclk_i);
    check("sdo", sdo_oe_n, 1);
    ss_n <= 0;
    repeat (4) @(posedge mclk_i);
    check("sdo", sdo_oe_n, 0);
    tx = $urandom;
    send(tx);
    for (n = 0; n < 3; n = n + 1) begin
      d = $urandom;
      spi(d, 8);
      if (n == 0) check("sdo data", got, tx);
      if (n < 2) q.push_back(d);
    end
    check("irq", irq, 1);
    check("wake", woke, 1);
    drain;
    cke <= 1;
    d = $urandom;
    spi(d, 8);
    q.push_back(d);
    drain;
    en <= 0;
    clock_polarity_bit <= 1;
    sck <= 1;
    mode <= 4'h5;
    ss_n <= 1;
    sdo_in <= 1;
    cke <= 0;
    repeat (4) @(posedge mclk_i);
    en <= 1;
    d = $urandom;
    spi(d, 8);
    q.push_back(d);
    check("sdo", sdo_oe_n, 1);
    drain;
    $display("slave receive done");
    report_and_stop;
  end
endmodule // serial_port_i2c_tx_spi_slave_test
